/* File: shared/serial_wait_pkg.sv */
// constants shared by the serial shift/wait device end and the bus controller end
// assumes a 20 MHz aclk and a link clock made by the controller end
package serial_wait_pkg;
	// device register offsets
	localparam logic [3:0] OFS_SHIFT     = 4'h3;
	localparam logic [3:0] OFS_WAIT_CTRL = 4'hA;
	// wait/interrupt timing control fields
	localparam int         WT_LO_BIT     = 0;
	localparam int         WT_HI_BIT     = 1;
	localparam int         WREL_BIT      = 2;
	localparam int         CLC_BIT       = 3;
	localparam logic [3:0] WAIT_CTRL_RST = 4'h0;
	localparam logic [7:0] SHIFT_RST     = 8'h00;
	// operating modes
	localparam logic [1:0] MODE_3WIRE    = 2'h0;
	localparam logic [1:0] MODE_2WIRE    = 2'h1;
	localparam logic [1:0] MODE_VBUS     = 2'h2;
	localparam logic [1:0] MODE_I2C      = 2'h3;
	// last transfer clock index, counted from zero, and the data bit count
	localparam logic [3:0] LAST_OF_8     = 4'h7;
	localparam logic [3:0] LAST_OF_9     = 4'h8;
	localparam logic [3:0] DATA_BITS     = 4'h8;
	// controller registers
	localparam logic [4:0] OFS_CMD       = 5'h00;
	localparam logic [4:0] OFS_TXD       = 5'h04;
	localparam logic [4:0] OFS_RXD       = 5'h08;
	localparam logic [4:0] OFS_IRQ_ST    = 5'h0C;
	localparam logic [4:0] OFS_IRQ_MASK  = 5'h10;
	localparam int         CMD_GO        = 0;
	localparam int         CMD_START     = 1;
	localparam int         CMD_STOP      = 2;
	localparam int         CMD_RX        = 3;
	localparam int         CMD_ACK       = 4;
	localparam int         CMD_BUSY      = 5;
	localparam int         IRQ_DONE      = 0;
	localparam int         IRQ_NACK      = 1;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;
	// link timing
	localparam int         CLK_NS        = 50;
	localparam int         LINK_HALF_NS  = 200;
	localparam logic [3:0] HALF_LAST     =
		4'((LINK_HALF_NS + CLK_NS - 1) / CLK_NS - 1);
endpackage : serial_wait_pkg

/* File: shared/serial_link_if.sv */
// open-drain two-wire link joining the device end and the controller end
// both ends only pull low; a released line reads high
`timescale 1ns/1ps
`default_nettype none
interface serial_link_if;
	logic dev_scl_o;
	logic dev_scl_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic ctl_scl_o;
	logic ctl_scl_oe;
	logic ctl_sda_o;
	logic ctl_sda_oe;
	logic scl;
	logic sda;

	assign scl = ~((dev_scl_oe & ~dev_scl_o) | (ctl_scl_oe & ~ctl_scl_o));
	assign sda = ~((dev_sda_oe & ~dev_sda_o) | (ctl_sda_oe & ~ctl_sda_o));

	modport device (
		input  scl,
		input  sda,
		output dev_scl_o,
		output dev_scl_oe,
		output dev_sda_o,
		output dev_sda_oe
	);
	modport ctrl (
		input  scl,
		input  sda,
		output ctl_scl_o,
		output ctl_scl_oe,
		output ctl_sda_o,
		output ctl_sda_oe
	);
endinterface : serial_link_if
`default_nettype wire

/* File: rtl/serial_wait_shift_control.sv */
// device end: 8-bit shift register, wait and interrupt timing control
// assumes the far end makes the link clock; registers reached by a simple port
// Notes on behaviour
// - timing 00/01: interrupt at 8th rise, no wait
// - timing 10, I2C: irq 8th rise, then hold SCL
// - timing 11, I2C: irq 9th rise, then hold SCL
// - wait release bit ends wait, self clears
// - software sets release only while waiting
// - wait release bit always reads zero
// - clock level bit 1 floats SCL, 0 none
// - software sets clock level bit for start/stop
// - wait ends on release, shift write, disable
// - timing control register resets to zero
// - 8-bit shift: write sends, read receives
// - 2-wire receive: preload all ones first
// - I2C receive: busy enable, then all ones
// - bus-mode receiver preloads all ones
// - bus mode: shift write drops busy only
// - wake-up set: irq only on address match
`timescale 1ns/1ps
`default_nettype none
module serial_wait_shift_control (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// register access
	input  wire logic [3:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	// mode and configuration
	input  wire logic       serial_if_enable,
	input  wire logic [1:0] mode_sel,
	input  wire logic       busy_enable_bit,
	input  wire logic       wakeup_mode_bit,
	input  wire logic       addr_match,
	// status
	output logic            serial_irq,
	output logic            busy_out,
	output logic            wait_active,
	// serial link
	serial_link_if.device   lnk
);
	logic       scl_s1_ff;
	logic       scl_s2_ff;
	logic       scl_d_ff;
	logic       sda_s1_ff;
	logic       sda_s2_ff;
	logic       sda_d_ff;
	logic [1:0] wat_ff;
	logic       clc_ff;
	logic       wrel_ff;
	logic [7:0] shift_ff;
	logic [3:0] bit_cnt_ff;
	logic       out_bit_ff;
	logic       wait_arm_ff;
	logic       wait_ff;
	logic       irq_ff;
	logic       busy_ff;
	logic [7:0] rdata_ff;
	logic       is_i2c;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_seen;
	logic [3:0] last_cnt;
	logic [3:0] wrap_cnt;
	logic       last_rise;
	logic       wr_shift;
	logic       wr_ctrl;
	logic       release_req;

	assign is_i2c     = (mode_sel == serial_wait_pkg::MODE_I2C);
	assign scl_rise   = scl_s2_ff & ~scl_d_ff;
	assign scl_fall   = ~scl_s2_ff & scl_d_ff;
	// start condition restarts the bit count
	assign start_seen = is_i2c & scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
	assign last_cnt   = (is_i2c && wat_ff == 2'b11) ?
		serial_wait_pkg::LAST_OF_9 : serial_wait_pkg::LAST_OF_8;
	// I2C byte always spans nine clocks, so the acknowledge slot never shifts in
	assign wrap_cnt   = is_i2c ? serial_wait_pkg::LAST_OF_9 : serial_wait_pkg::LAST_OF_8;
	assign last_rise  = scl_rise & (bit_cnt_ff == last_cnt) & serial_if_enable;
	assign wr_shift   = reg_wr & (reg_addr == serial_wait_pkg::OFS_SHIFT);
	assign wr_ctrl    = reg_wr & (reg_addr == serial_wait_pkg::OFS_WAIT_CTRL);
	assign release_req = (wr_ctrl & reg_wdata[serial_wait_pkg::WREL_BIT]) | wrel_ff
		| wr_shift | ~serial_if_enable;

	// link inputs cross from the far end's timing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_s1_ff <= 1'b1;
			scl_s2_ff <= 1'b1;
			scl_d_ff  <= 1'b1;
			sda_s1_ff <= 1'b1;
			sda_s2_ff <= 1'b1;
			sda_d_ff  <= 1'b1;
		end else begin
			scl_s1_ff <= lnk.scl;
			scl_s2_ff <= scl_s1_ff;
			scl_d_ff  <= scl_s2_ff;
			sda_s1_ff <= lnk.sda;
			sda_s2_ff <= sda_s1_ff;
			sda_d_ff  <= sda_s2_ff;
		end
	end

	// wait/interrupt timing control register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wat_ff <= serial_wait_pkg::WAIT_CTRL_RST[1:0];
			clc_ff <= serial_wait_pkg::WAIT_CTRL_RST[serial_wait_pkg::CLC_BIT];
		end else if (wr_ctrl) begin
			wat_ff <= {reg_wdata[serial_wait_pkg::WT_HI_BIT],
				reg_wdata[serial_wait_pkg::WT_LO_BIT]};
			clc_ff <= reg_wdata[serial_wait_pkg::CLC_BIT];
		end
	end

	// release bit lives only until the wait has dropped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wrel_ff <= serial_wait_pkg::WAIT_CTRL_RST[serial_wait_pkg::WREL_BIT];
		end else if (wr_ctrl && reg_wdata[serial_wait_pkg::WREL_BIT]) begin
			wrel_ff <= 1'b1;
		end else if (!wait_ff && !wait_arm_ff) begin
			wrel_ff <= 1'b0;
		end
	end

	// shift register and bit counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift_ff   <= serial_wait_pkg::SHIFT_RST;
			bit_cnt_ff <= 4'h0;
		end else if (wr_shift) begin
			shift_ff   <= reg_wdata;
			bit_cnt_ff <= 4'h0;
		end else if (!serial_if_enable || start_seen) begin
			bit_cnt_ff <= 4'h0;
		end else if (scl_rise) begin
			if (bit_cnt_ff < serial_wait_pkg::DATA_BITS) begin
				shift_ff <= {shift_ff[6:0], sda_s2_ff};
			end
			if (bit_cnt_ff == wrap_cnt) begin
				bit_cnt_ff <= 4'h0;
			end else begin
				bit_cnt_ff <= bit_cnt_ff + 4'h1;
			end
		end
	end

	// output bit changes at an SCL fall, or at once on a shift write or a disable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_bit_ff <= 1'b1;
		end else if (wr_shift) begin
			out_bit_ff <= reg_wdata[7];
		end else if (!serial_if_enable) begin
			out_bit_ff <= 1'b1;
		end else if (scl_fall) begin
			// ninth slot is left to the receiver
			out_bit_ff <= (bit_cnt_ff < serial_wait_pkg::DATA_BITS) ?
				shift_ff[7] : 1'b1;
		end
	end

	// wait: armed at the last rise, SCL pulled at the next fall
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wait_arm_ff <= 1'b0;
			wait_ff     <= 1'b0;
		end else if (release_req) begin
			wait_arm_ff <= 1'b0;
			wait_ff     <= 1'b0;
		end else if (last_rise && is_i2c && wat_ff[1]) begin
			wait_arm_ff <= 1'b1;
		end else if (wait_arm_ff && scl_fall) begin
			wait_arm_ff <= 1'b0;
			wait_ff     <= 1'b1;
		end
	end

	// interrupt pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= last_rise & (~wakeup_mode_bit | addr_match);
		end
	end

	// bus-mode busy: shift write drops it, busy enable stays as set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_ff <= 1'b0;
		end else if (wr_shift || !serial_if_enable) begin
			busy_ff <= 1'b0;
		end else if (last_rise && busy_enable_bit
			&& mode_sel == serial_wait_pkg::MODE_VBUS) begin
			busy_ff <= 1'b1;
		end
	end

	// read data, one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata_ff <= 8'h00;
		end else if (reg_addr == serial_wait_pkg::OFS_SHIFT) begin
			rdata_ff <= shift_ff;
		end else if (reg_addr == serial_wait_pkg::OFS_WAIT_CTRL) begin
			rdata_ff <= {4'h0, clc_ff, 1'b0, wat_ff};
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	assign reg_rdata   = rdata_ff;
	assign serial_irq  = irq_ff;
	assign busy_out    = busy_ff;
	assign wait_active = wait_ff;

	// pins only ever pull low; floating SCL overrides a held wait
	assign lnk.dev_scl_o  = 1'b0;
	assign lnk.dev_scl_oe = wait_ff & ~(is_i2c & clc_ff);
	assign lnk.dev_sda_o  = 1'b0;
	assign lnk.dev_sda_oe = serial_if_enable & ~out_bit_ff;
endmodule : serial_wait_shift_control
`default_nettype wire

/* File: rtl/serial_bus_controller.sv */
// far end: two-wire bus master ordered by software over AXI4-Lite
// assumes an open-drain link; honours a slave holding SCL low
`timescale 1ns/1ps
`default_nettype none
module serial_bus_controller (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// write address and data
	input  wire logic [4:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// read
	input  wire logic [4:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// interrupt
	output logic             irq,
	// serial link
	serial_link_if.ctrl      lnk
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_REP, ST_START, ST_LOW, ST_HIGH, ST_STOP_A, ST_STOP_B
	} link_state_e;

	link_state_e st_ff;
	logic        aw_hold_ff;
	logic [4:0]  awaddr_ff;
	logic        w_hold_ff;
	logic [31:0] wdata_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;
	logic [4:0]  cmd_ff;
	logic [7:0]  txd_ff;
	logic [1:0]  irq_st_ff;
	logic [1:0]  irq_mask_ff;
	logic        irq_ff;
	logic        go_ff;
	logic [3:0]  cnt_ff;
	logic [3:0]  bit_ff;
	logic [7:0]  sh_ff;
	logic        scl_oe_ff;
	logic        sda_oe_ff;
	logic [1:0]  ev_ff;
	logic        scl_s1_ff;
	logic        scl_s2_ff;
	logic        sda_s1_ff;
	logic        sda_s2_ff;
	logic        do_wr;
	logic        do_rd;
	logic        half;
	logic        wr_ok;
	logic [1:0]  rd_clr;

	assign do_wr  = aw_hold_ff & w_hold_ff & ~bvalid_ff;
	assign do_rd  = arvalid & ~rvalid_ff;
	assign half   = (cnt_ff == serial_wait_pkg::HALF_LAST);
	assign wr_ok  = (awaddr_ff == serial_wait_pkg::OFS_CMD)
		| (awaddr_ff == serial_wait_pkg::OFS_TXD)
		| (awaddr_ff == serial_wait_pkg::OFS_IRQ_MASK);
	assign rd_clr = (do_rd && araddr == serial_wait_pkg::OFS_IRQ_ST) ? irq_st_ff : 2'b00;

	// write channels taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			awaddr_ff  <= 5'h00;
			w_hold_ff  <= 1'b0;
			wdata_ff   <= 32'h00000000;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= serial_wait_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_hold_ff <= 1'b1;
				awaddr_ff  <= awaddr;
			end
			if (wvalid && wready) begin
				w_hold_ff <= 1'b1;
				wdata_ff  <= wdata;
			end
			if (do_wr) begin
				aw_hold_ff <= 1'b0;
				w_hold_ff  <= 1'b0;
				bvalid_ff  <= 1'b1;
				bresp_ff   <= wr_ok ? serial_wait_pkg::RESP_OKAY
					: serial_wait_pkg::RESP_SLVERR;
			end else if (bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// software registers; wstrb lane 0 carries every field
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_ff      <= 5'h00;
			txd_ff      <= 8'h00;
			irq_mask_ff <= 2'b00;
			go_ff       <= 1'b0;
		end else begin
			if (st_ff != ST_IDLE) begin
				go_ff <= 1'b0;
			end
			if (do_wr && wstrb[0]) begin
				unique case (awaddr_ff)
					serial_wait_pkg::OFS_CMD: begin
						cmd_ff <= wdata_ff[4:0];
						go_ff  <= wdata_ff[serial_wait_pkg::CMD_GO];
					end
					serial_wait_pkg::OFS_TXD:      txd_ff      <= wdata_ff[7:0];
					serial_wait_pkg::OFS_IRQ_MASK: irq_mask_ff <= wdata_ff[1:0];
					default: ;
				endcase
			end
		end
	end

	// sticky events, cleared by reading; a new event wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_st_ff <= 2'b00;
			irq_ff    <= 1'b0;
		end else begin
			irq_st_ff <= (irq_st_ff & ~rd_clr) | ev_ff;
			irq_ff    <= |(((irq_st_ff & ~rd_clr) | ev_ff) & irq_mask_ff);
		end
	end

	// read channel, answer one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h00000000;
			rresp_ff  <= serial_wait_pkg::RESP_OKAY;
		end else if (do_rd) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= serial_wait_pkg::RESP_OKAY;
			unique case (araddr)
				serial_wait_pkg::OFS_CMD:
					rdata_ff <= {26'h0, (st_ff != ST_IDLE) | go_ff, cmd_ff[4:1], 1'b0};
				serial_wait_pkg::OFS_TXD:      rdata_ff <= {24'h0, txd_ff};
				serial_wait_pkg::OFS_RXD:      rdata_ff <= {24'h0, sh_ff};
				serial_wait_pkg::OFS_IRQ_ST:   rdata_ff <= {30'h0, irq_st_ff};
				serial_wait_pkg::OFS_IRQ_MASK: rdata_ff <= {30'h0, irq_mask_ff};
				default: begin
					rdata_ff <= 32'h00000000;
					rresp_ff <= serial_wait_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// link level sampling
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_s1_ff <= 1'b1;
			scl_s2_ff <= 1'b1;
			sda_s1_ff <= 1'b1;
			sda_s2_ff <= 1'b1;
		end else begin
			scl_s1_ff <= lnk.scl;
			scl_s2_ff <= scl_s1_ff;
			sda_s1_ff <= lnk.sda;
			sda_s2_ff <= sda_s1_ff;
		end
	end

	// link engine: high phase counts only once SCL really is high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff     <= ST_IDLE;
			cnt_ff    <= 4'h0;
			bit_ff    <= 4'h0;
			sh_ff     <= 8'h00;
			scl_oe_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
			ev_ff     <= 2'b00;
		end else begin
			ev_ff  <= 2'b00;
			cnt_ff <= half ? 4'h0 : cnt_ff + 4'h1;
			unique case (st_ff)
				ST_IDLE: begin
					cnt_ff <= 4'h0;
					if (go_ff) begin
						sh_ff  <= txd_ff;
						bit_ff <= 4'h0;
						st_ff  <= cmd_ff[serial_wait_pkg::CMD_START] ? ST_REP : ST_LOW;
					end
				end
				ST_REP: begin
					sda_oe_ff <= 1'b0;
					scl_oe_ff <= 1'b0;
					if (half) begin
						st_ff <= ST_START;
					end
				end
				ST_START: begin
					sda_oe_ff <= 1'b1;
					if (half) begin
						scl_oe_ff <= 1'b1;
						st_ff     <= ST_LOW;
					end
				end
				ST_LOW: begin
					scl_oe_ff <= ~half;
					// as receiver the data line is left free for the eight data bits; the ninth slot is pulled low when CMD_ACK is set
					sda_oe_ff <= (bit_ff < serial_wait_pkg::DATA_BITS) ?
						(~cmd_ff[serial_wait_pkg::CMD_RX] & ~sh_ff[7]) :
						(cmd_ff[serial_wait_pkg::CMD_RX] & cmd_ff[serial_wait_pkg::CMD_ACK]);
					if (half) begin
						st_ff <= ST_HIGH;
					end
				end
				ST_HIGH: begin
					if (!scl_s2_ff) begin
						cnt_ff <= 4'h0;
					end else if (half) begin
						scl_oe_ff <= 1'b1;
						if (bit_ff < serial_wait_pkg::DATA_BITS) begin
							sh_ff  <= {sh_ff[6:0], sda_s2_ff};
							bit_ff <= bit_ff + 4'h1;
							st_ff  <= ST_LOW;
						end else begin
							ev_ff[serial_wait_pkg::IRQ_DONE] <= 1'b1;
							ev_ff[serial_wait_pkg::IRQ_NACK] <=
								sda_s2_ff & ~cmd_ff[serial_wait_pkg::CMD_RX];
							st_ff <= cmd_ff[serial_wait_pkg::CMD_STOP] ? ST_STOP_A : ST_IDLE;
						end
					end
				end
				ST_STOP_A: begin
					sda_oe_ff <= 1'b1;
					if (half) begin
						scl_oe_ff <= 1'b0;
						st_ff     <= ST_STOP_B;
					end
				end
				ST_STOP_B: begin
					if (!scl_s2_ff) begin
						cnt_ff <= 4'h0;
					end else if (half) begin
						sda_oe_ff <= 1'b0;
						st_ff     <= ST_IDLE;
					end
				end
			endcase
		end
	end

	assign awready = ~aw_hold_ff & ~bvalid_ff;
	assign wready  = ~w_hold_ff & ~bvalid_ff;
	assign bvalid  = bvalid_ff;
	assign bresp   = bresp_ff;
	assign arready = ~rvalid_ff;
	assign rvalid  = rvalid_ff;
	assign rdata   = rdata_ff;
	assign rresp   = rresp_ff;
	assign irq     = irq_ff;

	assign lnk.ctl_scl_o  = 1'b0;
	assign lnk.ctl_scl_oe = scl_oe_ff;
	assign lnk.ctl_sda_o  = 1'b0;
	assign lnk.ctl_sda_oe = sda_oe_ff;
endmodule : serial_bus_controller
`default_nettype wire

/* File: tb/serial_wait_checker.sv */
// assertions on the device end of the serial link
// fed by name from the bench, beside the link interface
`timescale 1ns/1ps
`default_nettype none
module serial_wait_checker (
	// clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// register port and configuration
	input wire logic [3:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       serial_if_enable,
	input wire logic [1:0] mode_sel,
	input wire logic       wakeup_mode_bit,
	input wire logic       addr_match,
	// status and link
	input wire logic       serial_irq,
	input wire logic       busy_out,
	input wire logic       wait_active,
	input wire logic       dev_scl_oe
);
	logic [3:0] ctrl_ff;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// shadow of the last control write; release bit stored but never checked
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ctrl_ff <= serial_wait_pkg::WAIT_CTRL_RST;
		else if (reg_wr && reg_addr == serial_wait_pkg::OFS_WAIT_CTRL)
			ctrl_ff <= reg_wdata[3:0];
	end

	sequence s_ctrl_wr;
		reg_wr && reg_addr == serial_wait_pkg::OFS_WAIT_CTRL;
	endsequence
	sequence s_shift_wr;
		reg_wr && reg_addr == serial_wait_pkg::OFS_SHIFT;
	endsequence

	property p_release;
		s_ctrl_wr ##0 reg_wdata[2] |=> !dev_scl_oe && !wait_active;
	endproperty
	property p_shift_end;
		s_shift_wr |=> !dev_scl_oe && !wait_active;
	endproperty
	property p_disable_end;
		!serial_if_enable |=> !dev_scl_oe && !wait_active;
	endproperty
	property p_reads_zero;
		reg_addr == serial_wait_pkg::OFS_WAIT_CTRL |=> reg_rdata[2] == 1'b0;
	endproperty
	property p_wait_form;
		$rose(dev_scl_oe) |-> mode_sel == serial_wait_pkg::MODE_I2C && ctrl_ff[1];
	endproperty
	property p_float;
		ctrl_ff[3] && mode_sel == serial_wait_pkg::MODE_I2C |-> !dev_scl_oe;
	endproperty
	property p_irq_pulse;
		serial_irq |=> !serial_irq;
	endproperty
	property p_wakeup;
		wakeup_mode_bit && !addr_match |-> !serial_irq;
	endproperty
	property p_busy;
		s_shift_wr ##0 mode_sel == serial_wait_pkg::MODE_VBUS |=> !busy_out;
	endproperty

	a_release: assert property (p_release) else $error("wait kept after release");
	a_shift_end: assert property (p_shift_end) else $error("wait kept after shift write");
	a_disable_end: assert property (p_disable_end) else $error("wait kept while disabled");
	a_reads_zero: assert property (p_reads_zero) else $error("release bit read as one");
	a_wait_form: assert property (p_wait_form) else $error("wait in wrong timing mode");
	a_float: assert property (p_float) else $error("clock line driven while floated");
	a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than a cycle");
	a_wakeup: assert property (p_wakeup) else $error("interrupt without address match");
	a_busy: assert property (p_busy) else $error("busy kept after shift write");
endmodule : serial_wait_checker
`default_nettype wire

/* File: tb/tb_serial_wait_shift_control.sv */
// bench joining the device end and the controller end over the link
// drives the device register port and the controller over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
	$display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_serial_wait_shift_control;
	logic        aclk = 1'b0;
	logic        aresetn, reg_wr, serial_if_enable, busy_enable_bit;
	logic        wakeup_mode_bit, addr_match, serial_irq, busy_out, wait_active, irq;
	logic [3:0]  reg_addr, wstrb;
	logic [7:0]  reg_wdata, reg_rdata, v8, base;
	logic [1:0]  mode_sel, rsp, bresp, rresp;
	logic [4:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, d32;
	logic        scl_q = 1'b1;
	logic [7:0]  n_rise = 8'h00, irq_at = 8'h00, n_sirq = 8'h00;
	logic [7:0]  wire_byte = 8'h00, wire_at = 8'h00;
	int          n_mismatch = 0, n_compared = 0;
	logic [1:0]  t_wt [5] = '{2'h3, 2'h2, 2'h2, 2'h1, 2'h0};
	logic [1:0]  t_how [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
	logic [7:0]  t_tx [5] = '{8'hA5, 8'h81, 8'h5A, 8'h3C, 8'hC3};

	serial_link_if lnk ();
	serial_wait_shift_control i_serial_wait_shift_control (.aclk, .aresetn, .reg_addr,
		.reg_wr, .reg_wdata, .reg_rdata, .serial_if_enable, .mode_sel, .busy_enable_bit,
		.wakeup_mode_bit, .addr_match, .serial_irq, .busy_out, .wait_active, .lnk(lnk));
	serial_bus_controller i_serial_bus_controller (.aclk, .aresetn, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq, .lnk(lnk));
	serial_wait_checker i_serial_wait_checker (.aclk, .aresetn, .reg_addr, .reg_wr,
		.reg_wdata, .reg_rdata, .serial_if_enable, .mode_sel, .wakeup_mode_bit,
		.addr_match, .serial_irq, .busy_out, .wait_active, .dev_scl_oe(lnk.dev_scl_oe));

	always #25 aclk = ~aclk;

	// wire-side view: bits seen at each clock rise, counted from the start
	always @(posedge aclk) begin
		scl_q <= lnk.scl;
		if (lnk.scl && !scl_q) begin
			n_rise <= n_rise + 8'h01;
			wire_byte <= {wire_byte[6:0], lnk.sda};
		end
		if (serial_irq) begin
			irq_at <= n_rise;
			wire_at <= wire_byte;
			n_sirq <= n_sirq + 8'h01;
		end
	end

	task automatic dev_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge aclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge aclk);
		reg_wr <= 1'b0;
	endtask : dev_wr

	task automatic dev_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge aclk);
		reg_addr <= a;
		@(posedge aclk);
		@(posedge aclk);
		d = reg_rdata;
	endtask : dev_rd

	task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask : axi_wr

	task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask : axi_rd

	task automatic tally_and_finish();
		$display("compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish

	// about a hundred and ten cycles a transfer; generous margin
	initial begin
		#(50 * 30000);
		n_mismatch++;
		tally_and_finish();
	end

	initial begin
		{aresetn, reg_wr, wakeup_mode_bit, addr_match, awvalid, wvalid, bready} = '0;
		{arvalid, rready, reg_addr, reg_wdata, awaddr, araddr, wdata, wstrb} = '0;
		serial_if_enable = 1'b1;
		busy_enable_bit = 1'b1;
		mode_sel = serial_wait_pkg::MODE_I2C;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		dev_rd(serial_wait_pkg::OFS_WAIT_CTRL, v8); `CHK(v8, 8'h00)
		dev_wr(serial_wait_pkg::OFS_WAIT_CTRL, 8'h0B);
		dev_rd(serial_wait_pkg::OFS_WAIT_CTRL, v8); `CHK(v8, 8'h0B)
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		dev_rd(serial_wait_pkg::OFS_WAIT_CTRL, v8); `CHK(v8, 8'h00)
		$display("test reset done");
		axi_wr(serial_wait_pkg::OFS_IRQ_MASK, 32'h1, rsp);
		for (int i = 0; i < 5; i++) begin
			dev_wr(serial_wait_pkg::OFS_WAIT_CTRL, {6'h00, t_wt[i]});
			dev_wr(serial_wait_pkg::OFS_SHIFT, 8'hFF);
			axi_wr(serial_wait_pkg::OFS_TXD, {24'h0, t_tx[i]}, rsp);
			base = n_rise;
			axi_wr(serial_wait_pkg::OFS_CMD, 32'h7, rsp);
			while (serial_irq !== 1'b1) @(posedge aclk);
			@(posedge aclk);
			`CHK(irq_at - base, t_wt[i] == 2'h3 ? 8'h09 : 8'h08)
			`CHK(wire_at, t_wt[i] == 2'h3 ? {t_tx[i][6:0], 1'b1} : t_tx[i])
			dev_rd(serial_wait_pkg::OFS_SHIFT, v8); `CHK(v8, t_tx[i])
			if (t_wt[i][1]) begin
				while (wait_active !== 1'b1) @(posedge aclk);
				@(posedge aclk);
				`CHK(lnk.dev_scl_oe, 1'b1)
				case (t_how[i])
					2'h0: begin
						dev_wr(serial_wait_pkg::OFS_WAIT_CTRL, 8'h0B);
						@(posedge aclk);
						`CHK(lnk.dev_scl_oe, 1'b0)
						dev_wr(serial_wait_pkg::OFS_WAIT_CTRL, 8'h07);
					end
					2'h1: dev_wr(serial_wait_pkg::OFS_SHIFT, 8'hFF);
					default: begin
						@(posedge aclk);
						serial_if_enable <= 1'b0;
						@(posedge aclk);
						serial_if_enable <= 1'b1;
						@(posedge aclk);
					end
				endcase
				@(posedge aclk);
				`CHK(wait_active, 1'b0)
				`CHK(lnk.dev_scl_oe, 1'b0)
				dev_rd(serial_wait_pkg::OFS_WAIT_CTRL, v8); `CHK(v8, {6'h00, t_wt[i]})
			end
			while (irq !== 1'b1) @(posedge aclk);
			axi_rd(serial_wait_pkg::OFS_IRQ_ST, d32, rsp); `CHK(d32[1:0], 2'h3)
			$display("test wait timing %0d done", i);
		end
		dev_wr(serial_wait_pkg::OFS_WAIT_CTRL, 8'h00);
		dev_wr(serial_wait_pkg::OFS_SHIFT, 8'h96);
		wakeup_mode_bit <= 1'b1;
		base = n_sirq;
		axi_wr(serial_wait_pkg::OFS_CMD, 32'hF, rsp);
		while (irq !== 1'b1) @(posedge aclk);
		`CHK(n_sirq, base)
		axi_rd(serial_wait_pkg::OFS_RXD, d32, rsp); `CHK(d32[7:0], 8'h96)
		axi_wr(serial_wait_pkg::OFS_IRQ_MASK, 32'h0, rsp);
		@(posedge aclk);
		`CHK(irq, 1'b0)
		axi_wr(serial_wait_pkg::OFS_IRQ_MASK, 32'h1, rsp);
		@(posedge aclk);
		`CHK(irq, 1'b1)
		axi_rd(serial_wait_pkg::OFS_IRQ_ST, d32, rsp); `CHK(d32[1:0], 2'h1)
		@(posedge aclk);
		`CHK(irq, 1'b0)
		axi_rd(5'h14, d32, rsp); `CHK(rsp, serial_wait_pkg::RESP_SLVERR)
		axi_wr(serial_wait_pkg::OFS_RXD, 32'h0, rsp); `CHK(rsp, serial_wait_pkg::RESP_SLVERR)
		$display("test receive and interrupt done");
		mode_sel <= serial_wait_pkg::MODE_VBUS;
		addr_match <= 1'b1;
		dev_wr(serial_wait_pkg::OFS_SHIFT, 8'hFF);
		base = n_sirq;
		axi_wr(serial_wait_pkg::OFS_CMD, 32'h7, rsp);
		while (busy_out !== 1'b1) @(posedge aclk);
		`CHK(busy_out, 1'b1)
		dev_wr(serial_wait_pkg::OFS_SHIFT, 8'h00);
		@(posedge aclk);
		`CHK(busy_out, 1'b0)
		`CHK(n_sirq, base + 8'h01)
		$display("test bus mode busy done");
		tally_and_finish();
	end
endmodule : tb_serial_wait_shift_control
`default_nettype wire
